// [logic/jtb_pkg.sv]
// Purpose: Shared constants and types for the boundary-scan test access port.
// Assumes: A tester drives the serial test link; the core runs on core_clk.
// Notes:   Pin counts are plain defaults sized for a small scan chain.
//
// Overview of operation
// R01 - The block holds a sixteen-state controller, a six-bit instruction register and five test pins.
// R02 - Pulling the active-low test reset low resets the controller at once, with no test-clock edge.
// R03 - Mode select and serial data in are sampled on the rising test-clock edge.
// R04 - Serial data out changes on the falling test-clock edge.
// R05 - Serial data out is floated except while in the shift-data or shift-instruction state.
// R06 - The controller moves only by the mode select value taken at each rising edge.
// R07 - Five rising edges with mode select high bring the controller to reset from any state.
// R08 - The boundary chain observes and drives the DC pins so board wiring can be tested.
// R09 - No AC-coupled test mode exists; such pins get no time-varying test signal.
// R10 - Serial data in feeds whichever register is selected for shifting.
// R11 - An identification instruction lets the tester read out a part identification value.
// R12 - Bypass, boundary and identification registers sit in parallel, chosen by the instruction.
// R13 - Next-state decoding follows the standard sixteen-state test access port graph.
// R14 - Each shift edge moves the selected register one bit toward the output, low bit first.

package jtb_pkg;

  // Controller states, in the order of the standard graph.
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHF_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHF_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } jtb_state_t;

  // Register widths.
  localparam int unsigned JTB_IR_W   = 6;
  localparam int unsigned JTB_ID_W   = 32;
  localparam int unsigned JTB_NUM_IN = 8;
  localparam int unsigned JTB_NUM_OUT = 8;
  localparam int unsigned JTB_BSR_W  = JTB_NUM_IN + JTB_NUM_OUT + 1;

  // Field positions inside the boundary chain, low end nearest the output.
  localparam int unsigned JTB_BSR_IN_LSB  = 0;
  localparam int unsigned JTB_BSR_OUT_LSB = JTB_NUM_IN;
  localparam int unsigned JTB_BSR_OE_POS  = JTB_NUM_IN + JTB_NUM_OUT;

  // Instruction codes; every other code selects bypass.
  localparam logic [JTB_IR_W-1:0] JTB_INST_EXTEST = 6'h00;
  localparam logic [JTB_IR_W-1:0] JTB_INST_SAMPLE = 6'h01;
  localparam logic [JTB_IR_W-1:0] JTB_INST_IDCODE = 6'h02;
  localparam logic [JTB_IR_W-1:0] JTB_INST_BYPASS = 6'h3F;

  // Values loaded at capture or after reset.
  localparam logic [JTB_IR_W-1:0] JTB_IR_CAPTURE = 6'h01;
  localparam logic [JTB_IR_W-1:0] JTB_IR_RESET   = JTB_INST_IDCODE;
  localparam logic [JTB_ID_W-1:0] JTB_ID_DEFAULT = 32'h0000_0001; // Arbitrary value.
  localparam logic                JTB_TDO_RESET  = 1'h0;

  // Pin drive word handed from the test clock domain to the core domain.
  typedef struct packed {
    logic                   extest;
    logic                   oe;
    logic [JTB_NUM_OUT-1:0] out;
  } jtb_drive_t;

endpackage : jtb_pkg

// [logic/jtb_sync3.sv]
// Purpose: Three-stage synchroniser for levels arriving from another clock domain.
// Assumes: Each bit may be sampled independently; words need their own handshake.
// Notes:   A bit is accepted only once the second and third stages agree.

`timescale 1ns/10ps

module jtb_sync3
  import jtb_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // Capture chain; the first stage feeds only the second.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Each output bit moves only when the two later stages agree.
  always_ff @(posedge clk)
  begin
    if (rst)
      dout <= '0;
    else
      dout <= (s2_reg & s3_reg) | (dout & (s2_reg ^ s3_reg));
  end

endmodule : jtb_sync3

// [logic/jtb_tap.sv]
// Purpose: Test access port with instruction, bypass, identification and boundary registers.
// Assumes: tck comes from the tester and may stop between scans; core_clk runs free.
// Notes:   The pin drive word crosses to core_clk by a toggle with the word held stable.

`timescale 1ns/10ps

module jtb_tap
  import jtb_pkg::*;
#(
  parameter logic [JTB_ID_W-1:0] ID_VALUE = JTB_ID_DEFAULT // Arbitrary value.
)
(
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  input  wire logic                   tck,
  input  wire logic                   trst_n,
  input  wire logic                   tms,
  input  wire logic                   tdi,
  output logic                        tdo,
  output logic                        tdo_oe,
  input  wire logic [JTB_NUM_IN-1:0]  pin_in,
  input  wire logic [JTB_NUM_OUT-1:0] core_out,
  input  wire logic                   core_oe,
  output logic      [JTB_NUM_OUT-1:0] pad_out,
  output logic                        pad_oe
);

  jtb_state_t             state_reg;
  jtb_state_t             state_next;
  logic [JTB_IR_W-1:0]    ir_shift_reg;
  logic [JTB_IR_W-1:0]    ir_reg;
  logic [JTB_BSR_W-1:0]   bsr_shift_reg;
  logic [JTB_BSR_W-1:0]   bsr_upd_reg;
  logic [JTB_ID_W-1:0]    id_shift_reg;
  logic                   bypass_reg;
  logic                   tdo_next;
  logic                   sel_bsr;
  logic                   sel_id;
  logic                   drive_tog_reg;
  logic                   rst_pend_reg;
  logic [JTB_BSR_W-1:0]   pins_raw;
  logic [JTB_BSR_W-1:0]   pins_tck;
  jtb_drive_t             drive_tck;
  logic                   drive_tog_core;
  logic                   tog_seen_reg;
  jtb_drive_t             drive_core_reg;

  // Instruction decode; unknown codes fall through to bypass.
  // No AC-coupled test instruction is decoded, so no pin ever toggles on its own. [R09]
  assign sel_bsr = (ir_reg == JTB_INST_EXTEST) || (ir_reg == JTB_INST_SAMPLE); // [R12]
  assign sel_id  = (ir_reg == JTB_INST_IDCODE); // [R12]

  // Next-state decoding of the sixteen-state graph, steered by mode select only.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg) // [R13] [R06]
      TAP_RESET:  state_next = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   state_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_next = tms ? TAP_EX1_DR : TAP_SHF_DR;
      TAP_SHF_DR: state_next = tms ? TAP_EX1_DR : TAP_SHF_DR;
      TAP_EX1_DR: state_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: state_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: state_next = tms ? TAP_UPD_DR : TAP_SHF_DR;
      TAP_UPD_DR: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_next = tms ? TAP_RESET  : TAP_CAP_IR; // [R07]
      TAP_CAP_IR: state_next = tms ? TAP_EX1_IR : TAP_SHF_IR;
      TAP_SHF_IR: state_next = tms ? TAP_EX1_IR : TAP_SHF_IR;
      TAP_EX1_IR: state_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: state_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: state_next = tms ? TAP_UPD_IR : TAP_SHF_IR;
      TAP_UPD_IR: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    state_next = TAP_RESET;
    endcase
  end

  // State register; the reset pin acts without waiting for a clock edge.
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      state_reg <= TAP_RESET; // [R02]
    else
      state_reg <= state_next; // [R03] [R01]
  end

  // Instruction shift stage: capture a fixed pattern, then shift low bit first.
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      ir_shift_reg <= JTB_IR_RESET;
    else if (state_reg == TAP_CAP_IR)
      ir_shift_reg <= JTB_IR_CAPTURE; // [R01]
    else if (state_reg == TAP_SHF_IR)
      ir_shift_reg <= {tdi, ir_shift_reg[JTB_IR_W-1:1]}; // [R10] [R14]
  end

  // Instruction register, loaded on the falling edge in update or forced in reset.
  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
      ir_reg <= JTB_IR_RESET;
    else if (state_reg == TAP_RESET)
      ir_reg <= JTB_IR_RESET; // [R07]
    else if (state_reg == TAP_UPD_IR)
      ir_reg <= ir_shift_reg;
  end

  // Bypass cell: captures zero and passes one bit through while shifting.
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      bypass_reg <= 1'h0;
    else if (state_reg == TAP_CAP_DR && !sel_bsr && !sel_id)
      bypass_reg <= 1'h0; // [R12]
    else if (state_reg == TAP_SHF_DR && !sel_bsr && !sel_id)
      bypass_reg <= tdi; // [R10]
  end

  // Identification register: loads the part value, then shifts it out.
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      id_shift_reg <= ID_VALUE;
    else if (state_reg == TAP_CAP_DR && sel_id)
      id_shift_reg <= ID_VALUE; // [R11]
    else if (state_reg == TAP_SHF_DR && sel_id)
      id_shift_reg <= {tdi, id_shift_reg[JTB_ID_W-1:1]}; // [R10] [R14]
  end

  // Pad states seen from the test clock side pass three stages first.
  assign pins_raw = {pad_oe, pad_out, pin_in};

  jtb_sync3 #(
    .WIDTH (JTB_BSR_W)
  ) u_pin_sync (
    .clk  (tck),
    .rst  (1'b0),
    .din  (pins_raw),
    .dout (pins_tck)
  );

  // Boundary chain: samples the DC pins at capture, shifts toward the output.
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      bsr_shift_reg <= '0;
    else if (state_reg == TAP_CAP_DR && sel_bsr)
      bsr_shift_reg <= pins_tck; // [R08]
    else if (state_reg == TAP_SHF_DR && sel_bsr)
      bsr_shift_reg <= {tdi, bsr_shift_reg[JTB_BSR_W-1:1]}; // [R10] [R14]
  end

  // Boundary update latches, loaded on the falling edge so skew cannot corrupt them.
  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
      bsr_upd_reg <= '0;
    else if (state_reg == TAP_UPD_DR && sel_bsr)
      bsr_upd_reg <= bsr_shift_reg; // [R08]
  end

  // Remembers a test reset until the first falling edge after it.
  // The toggle may already sit at its reset level, so without this the core would keep
  // driving the pads from an external test word that the reset has cancelled.
  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
      rst_pend_reg <= 1'h1;
    else
      rst_pend_reg <= 1'h0;
  end

  // Toggle flags each change of the drive word so the core can pick it up.
  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
      drive_tog_reg <= 1'h0;
    else if (state_reg == TAP_UPD_IR || (state_reg == TAP_UPD_DR && sel_bsr) ||
             (state_reg == TAP_RESET && ir_reg != JTB_IR_RESET) || rst_pend_reg)
      drive_tog_reg <= ~drive_tog_reg; // [R02]
  end

  // Drive word built only from test-side flops, so it is stable between toggles.
  assign drive_tck.extest = (ir_reg == JTB_INST_EXTEST);
  assign drive_tck.oe     = bsr_upd_reg[JTB_BSR_OE_POS];
  assign drive_tck.out    = bsr_upd_reg[JTB_BSR_OUT_LSB +: JTB_NUM_OUT];

  // Select the bit that leaves on the serial output.
  always_comb
  begin
    tdo_next = bypass_reg;
    case (state_reg)
      TAP_SHF_IR: tdo_next = ir_shift_reg[0]; // [R14]
      TAP_SHF_DR:
      begin
        if (sel_bsr)
          tdo_next = bsr_shift_reg[0]; // [R12]
        else if (sel_id)
          tdo_next = id_shift_reg[0];
        else
          tdo_next = bypass_reg;
      end
      default:    tdo_next = bypass_reg;
    endcase
  end

  // Serial output and its enable change on the falling edge, or at once on test reset.
  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tdo    <= JTB_TDO_RESET;
      tdo_oe <= 1'h0;
    end
    else
    begin
      tdo    <= tdo_next; // [R04]
      tdo_oe <= (state_reg == TAP_SHF_DR) || (state_reg == TAP_SHF_IR); // [R05]
    end
  end

  // Core side: the toggle passes three stages before the word is taken.
  jtb_sync3 #(
    .WIDTH (1)
  ) u_tog_sync (
    .clk  (core_clk),
    .rst  (srst),
    .din  (drive_tog_reg),
    .dout (drive_tog_core)
  );

  // Take a fresh copy of the drive word on each toggle change.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      tog_seen_reg   <= 1'h0;
      drive_core_reg <= '0;
    end
    else if (drive_tog_core != tog_seen_reg)
    begin
      tog_seen_reg   <= drive_tog_core;
      drive_core_reg <= drive_tck;
    end
  end

  // Pads follow the core unless the external test owns them.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pad_out <= '0;
      pad_oe  <= 1'h0;
    end
    else if (drive_core_reg.extest)
    begin
      pad_out <= drive_core_reg.out; // [R08]
      pad_oe  <= drive_core_reg.oe;
    end
    else
    begin
      pad_out <= core_out;
      pad_oe  <= core_oe;
    end
  end

  // Five rising edges with mode select high.
  sequence s_five_ones;
    tms [*5];
  endsequence

  // A capture followed by one shift edge.
  sequence s_ir_cap_shift;
    (state_reg == TAP_CAP_IR) ##1 (state_reg == TAP_SHF_IR);
  endsequence

  property p_five_reset;
    @(posedge tck) disable iff (!trst_n)
      s_five_ones |=> (state_reg == TAP_RESET);
  endproperty

  property p_ir_capture;
    @(posedge tck) disable iff (!trst_n)
      s_ir_cap_shift |=>
        (ir_shift_reg == {$past(tdi), JTB_IR_CAPTURE[JTB_IR_W-1:1]});
  endproperty

  a_five_ones_reset: assert property (p_five_reset) // [R07]
    else $error("Five high mode select edges did not reach reset.");

  a_ir_cap_shift: assert property (p_ir_capture) // [R14]
    else $error("Instruction capture or first shift is wrong.");

  a_trst_async: assert property ( // [R02]
    @(posedge core_clk) disable iff (srst)
      (!trst_n && !$rose(trst_n)) |-> (state_reg == TAP_RESET) && (tdo_oe == 1'h0))
    else $error("Test reset did not hold the controller in reset.");

  a_tdo_float_idle: assert property ( // [R05]
    @(posedge tck) disable iff (!trst_n)
      tdo_oe |-> (state_reg == TAP_SHF_DR || state_reg == TAP_SHF_IR))
    else $error("Serial output enabled outside a shift state.");

  a_tdo_bit_out: assert property ( // [R04]
    @(posedge tck) disable iff (!trst_n)
      (tdo_oe && state_reg == TAP_SHF_IR) |-> (tdo == ir_shift_reg[0]))
    else $error("Serial output does not show the low instruction bit.");

  a_bypass_capture: assert property ( // [R12]
    @(posedge tck) disable iff (!trst_n)
      (state_reg == TAP_CAP_DR && !sel_bsr && !sel_id) ##1 (state_reg == TAP_SHF_DR)
        |-> (bypass_reg == 1'h0) ##1 (bypass_reg == $past(tdi)))
    else $error("Bypass cell did not capture zero then pass data in.");

  a_idcode_load: assert property ( // [R11]
    @(posedge tck) disable iff (!trst_n)
      (state_reg == TAP_CAP_DR && sel_id) |=> (id_shift_reg == ID_VALUE))
    else $error("Identification value was not captured.");

  a_idle_hold: assert property ( // [R06]
    @(posedge tck) disable iff (!trst_n)
      (state_reg == TAP_IDLE && !tms) |=> (state_reg == TAP_IDLE))
    else $error("Controller left idle with mode select low.");

  a_reset_instr: assert property ( // [R13]
    @(posedge tck) disable iff (!trst_n)
      ($past(state_reg) == TAP_RESET && state_reg == TAP_RESET) |-> (ir_reg == JTB_IR_RESET))
    else $error("Reset state did not restore the identification instruction.");

  a_core_drive: assert property ( // [R08]
    @(posedge core_clk) disable iff (srst)
      !drive_core_reg.extest |=> (pad_out == $past(core_out)) && (pad_oe == $past(core_oe)))
    else $error("Pads did not follow the core outside external test.");

endmodule : jtb_tap

// [verif/jtb_tester.sv]
// Purpose: Behavioural boundary-scan tester that drives the serial test link.
// Assumes: The test clock runs only inside scans and rests low between them.
// Notes:   A floated data out reads back as the inverse of its last level.

`timescale 1ns/10ps

module jtb_tester
(
  output logic      tck,
  output logic      trst_n,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic last_tdo;
  logic oe_seen;

  // The link rests with the clock low and the reset released.
  initial
  begin
    tck = 1'h0;
    trst_n = 1'h1;
    tms = 1'h1;
    tdi = 1'h1;
    last_tdo = 1'h0;
    oe_seen = 1'h0;
  end

  // Drives the test reset level; the controller must react with no clock.
  task automatic set_reset(input logic v);
  begin
    trst_n = v;
  end
  endtask : set_reset

  // One 64 ns clock period; mode and data settle while the clock is low.
  task automatic step(input logic m, input logic d, output logic o);
  begin
    tms = m;
    tdi = d;
    #16;
    tck = 1'h1;
    o = tdo_oe ? tdo : ~last_tdo;
    oe_seen = tdo_oe;
    last_tdo = o;
    #32;
    tck = 1'h0;
    #16;
  end
  endtask : step

  // Pulses the reset, then walks from Test-Logic-Reset to Run-Test/Idle.
  task automatic reset_link();
    logic o;
  begin
    set_reset(1'h0);
    #40;
    set_reset(1'h1);
    #20;
    step(1'h0, 1'h0, o);
  end
  endtask : reset_link

  // Five mode-high clocks reach Test-Logic-Reset, one more clock goes to idle.
  task automatic five_ones();
    logic o;
  begin
    repeat (5) step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
  end
  endtask : five_ones

  // Full data or instruction scan from Run-Test/Idle back to Run-Test/Idle.
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_ok);
    logic o;
  begin
    dout = '0;
    oe_ok = 1'h1;
    step(1'h1, 1'h0, o);
    if (ir)
      step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
    step(1'h0, 1'h0, o);
    for (int i = 0; i < n; i++)
    begin
      step(logic'(i == n - 1), din[i], o);
      dout[i] = o;
      oe_ok &= oe_seen;
    end
    step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
    oe_ok &= !oe_seen;
  end
  endtask : scan
endmodule : jtb_tester

// [verif/tb.sv]
// Purpose: Self-checking bench for the boundary-scan test access port.
// Assumes: The tester model owns the test link; the bench drives the core side.
// Notes:   Pad values settle a handful of core clocks after each update.

`timescale 1ns/10ps

module tb
  import jtb_pkg::*;
;
  logic                   core_clk;
  logic                   srst;
  logic                   tck;
  logic                   trst_n;
  logic                   tms;
  logic                   tdi;
  logic                   tdo;
  logic                   tdo_oe;
  logic [JTB_NUM_IN-1:0]  pin_in;
  logic [JTB_NUM_OUT-1:0] core_out;
  logic                   core_oe;
  logic [JTB_NUM_OUT-1:0] pad_out;
  logic                   pad_oe;
  logic [31:0]            got;
  logic                   ok;
  int                     n_errors;
  int                     check_count;

  jtb_tap dut_u (.core_clk(core_clk), .srst(srst), .tck(tck), .trst_n(trst_n),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
    .core_out(core_out), .core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe));

  jtb_tester tester_u (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe));

  // Core clock at 40 MHz.
  initial
  begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Compares one value and counts the result.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got_v);
  begin
    check_count++;
    if (got_v !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got_v);
    end
  end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic summarize();
  begin
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask : summarize

  // After a test reset the identification value shifts out low bit first.
  task automatic t_idcode();
  begin
    tester_u.reset_link();
    check("tdo_oe idle", 32'h0, {31'h0, tdo_oe});
    tester_u.scan(1'h0, 32, 32'h0, got, ok);
    check("idcode", JTB_ID_DEFAULT, got);
    check("oe idcode", 32'h1, {31'h0, ok});
  end
  endtask : t_idcode

  // The instruction register captures its fixed pattern on a six-bit scan.
  task automatic t_ir_capture();
  begin
    tester_u.scan(1'h1, 6, {26'h0, JTB_INST_IDCODE}, got, ok);
    check("ir capture", {26'h0, JTB_IR_CAPTURE}, got);
    check("oe ir", 32'h1, {31'h0, ok});
  end
  endtask : t_ir_capture

  // Bypass and an unassigned code both give a one-bit path that captures 0.
  // Neither code may take the pads away from the core.
  task automatic t_bypass();
    logic [5:0] codes [2];
  begin
    codes[0] = JTB_INST_BYPASS;
    codes[1] = 6'h2A;
    foreach (codes[k])
    begin
      tester_u.scan(1'h1, 6, {26'h0, codes[k]}, got, ok);
      tester_u.scan(1'h0, 4, 32'hB, got, ok);
      check("bypass", 32'h6, got);
      repeat (10) @(posedge core_clk);
      #1;
      check("pads in bypass", 32'h1A5, {23'h0, pad_oe, pad_out});
    end
  end
  endtask : t_bypass

  // Sample, preload, extest, then a five-clock reset returns pads to the core.
  task automatic t_boundary();
  begin
    tester_u.scan(1'h1, 6, {26'h0, JTB_INST_SAMPLE}, got, ok);
    tester_u.scan(1'h0, JTB_BSR_W, 32'h1_C300, got, ok);
    check("sample capture", 32'h1_A53C, got);
    tester_u.scan(1'h1, 6, {26'h0, JTB_INST_EXTEST}, got, ok);
    repeat (10) @(posedge core_clk);
    #1;
    check("extest pads", 32'h1C3, {23'h0, pad_oe, pad_out});
    tester_u.five_ones();
    repeat (10) @(posedge core_clk);
    #1;
    check("pads after reset", 32'h1A5, {23'h0, pad_oe, pad_out});
    tester_u.scan(1'h0, 32, 32'h0, got, ok);
    check("idcode after reset", JTB_ID_DEFAULT, got);
  end
  endtask : t_boundary

  // Test reset in the middle of a data shift floats the output at once.
  task automatic t_async_reset();
    logic o;
  begin
    tester_u.step(1'h1, 1'h0, o);
    tester_u.step(1'h0, 1'h0, o);
    tester_u.step(1'h0, 1'h0, o);
    check("oe in shift", 32'h1, {31'h0, tdo_oe});
    tester_u.set_reset(1'h0);
    #5;
    check("oe at reset", 32'h0, {31'h0, tdo_oe});
    tester_u.reset_link();
    tester_u.scan(1'h0, 32, 32'h0, got, ok);
    check("idcode after trst", JTB_ID_DEFAULT, got);
  end
  endtask : t_async_reset

  // A data scan split by a pause resumes where it stopped and floats the output while paused.
  task automatic t_pause();
    logic        o;
    logic [15:0] bits;
  begin
    bits = '0;
    tester_u.step(1'h1, 1'h0, o);
    tester_u.step(1'h0, 1'h0, o);
    tester_u.step(1'h0, 1'h0, o);
    for (int i = 0; i < 8; i++)
    begin
      tester_u.step(logic'(i == 7), 1'h0, o);
      bits[i] = o;
    end
    tester_u.step(1'h0, 1'h0, o);
    tester_u.step(1'h0, 1'h0, o);
    check("oe in pause", 32'h0, {31'h0, tdo_oe});
    tester_u.step(1'h1, 1'h0, o);
    tester_u.step(1'h0, 1'h0, o);
    for (int i = 8; i < 16; i++)
    begin
      tester_u.step(logic'(i == 15), 1'h0, o);
      bits[i] = o;
    end
    tester_u.step(1'h1, 1'h0, o);
    tester_u.step(1'h0, 1'h0, o);
    check("paused idcode", {16'h0, JTB_ID_DEFAULT[15:0]}, {16'h0, bits});
  end
  endtask : t_pause

  // Core reset, then the scenarios in turn.
  initial
  begin
    n_errors = 0;
    check_count = 0;
    srst = 1'h1;
    pin_in = 8'h3C;
    core_out = 8'hA5;
    core_oe = 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    srst = 1'h0;
    repeat (4) @(posedge core_clk);
    t_idcode();
    t_ir_capture();
    t_bypass();
    t_boundary();
    t_async_reset();
    t_pause();
    summarize();
  end

  // Cuts a hang short well beyond the expected run time.
  initial
  begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule : tb
